// ===== hdl/sidc_ctrl.sv
// Interrupt, DMA routing and infrared control for four serial channels
// Behaviour
// - 2-bit infrared select: 00 normal, 10 infrared, 01/11 reserved.
// - Each channel has a 3-bit interrupt level 0 to 7.
// - Per-channel error, full, empty enables; even bits 0-2, odd 3-5; reset 0.
// - Event flag reads 1 after its event regardless of enable and level.
// - Clear-only style: 1 clears, 0 ignored; read/write style: write value.
// - Transmit-empty event when byte moves holding register to shifter.
// - Receive-full event when byte moves shifter to receive data register.
// - Receive-error event on parity, framing or overrun error.
// - CPU interrupt needs enable, no higher request, global allow, level above threshold.
// - DMA-routed full/empty events interrupt only after DMA completes, if allowed.
// - Flags clear only by software; a set flag requests again.
// - DMA request selects reset 0; set-only style or read/write style.
// - Select 1 starts DMA on the event; 0 gives a normal interrupt.
// - DMA allow bits reset 0, same styles; request passed only while allowed.
// - Receive error sets error and full flags; error has priority.
// - Control bit 7 allows transmit, bit 6 allows receive; both reset 0.
`timescale 1ns/1ps
`default_nettype none
module sidc_ctrl
  import sidc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [sidc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [sidc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel cores
  input wire sidc_pkg::sidc_evt_s [sidc_pkg::NCH-1:0] line_evt,
  output sidc_pkg::sidc_cfg_s [sidc_pkg::NCH-1:0] chan_cfg,
  // Programmed DMA engine
  output sidc_pkg::sidc_dma_s [sidc_pkg::NCH-1:0] dma_req,
  input wire sidc_pkg::sidc_dma_s [sidc_pkg::NCH-1:0] dma_done,
  input wire sidc_pkg::sidc_dma_s [sidc_pkg::NCH-1:0] dma_irq_allow,
  // CPU interrupt logic
  input wire logic global_irq_allow,
  input wire logic [2:0] cpu_irq_threshold,
  input wire logic higher_irq_pending,
  output sidc_pkg::sidc_irq_s [sidc_pkg::NCH-1:0] chan_irq,
  output logic cpu_irq_req,
  output logic [2:0] cpu_irq_level,
  output logic [1:0] cpu_irq_channel,
  output sidc_pkg::sidc_src_e cpu_irq_source
);
  import sidc_pkg::*;

  logic aw_got_q, w_got_q, bvalid_q, rvalid_q, wlane_q, style_q, wr_go, wr_en;
  logic [IDX_W-1:0] wix_q, rix;
  logic [7:0] wbyte_q, rd_byte;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] ctrl_q [NCH];
  logic [7:0] irs_q [NCH];
  logic [2:0] lvl_q [NCH];
  logic [2:0] en_q [NCH];
  logic [2:0] flag_q [NCH];
  logic [2:0] act [NCH];
  logic [1:0] dsel_q [NCH];
  logic [1:0] dal_q [NCH];
  logic [1:0] pend_q [NCH];
  logic [1:0] rel_q [NCH];
  logic [1:0] routed [NCH];
  sidc_irq_s [NCH-1:0] chan_irq_q;
  logic best_ok;
  logic [2:0] best_lvl;
  logic [1:0] best_ch;
  sidc_src_e best_src;
  logic cpu_irq_q;
  logic [2:0] cpu_lvl_q;
  logic [1:0] cpu_ch_q;
  sidc_src_e cpu_src_q;

  // True when an index names any register of the block
  function automatic logic reg_hit(input logic [IDX_W-1:0] ix);
    logic hit;
    hit = (ix == STYLE_IX);
    for (int c = 0; c < NCH; c++)
    begin
      hit = hit | (ix == CTRL_IX[c]) | (ix == IRS_IX[c]) | (ix == LVL_IX[c]);
      hit = hit | (ix == EN_IX[c]) | (ix == FLG_IX[c]) | (ix == DRQ_IX[c]);
      hit = hit | (ix == DAL_IX[c]);
    end
    return hit;
  endfunction

  // Write strobe for one register
  function automatic logic wr_at(input logic [IDX_W-1:0] ix);
    return wr_en && (wix_q == ix);
  endfunction

  // Set-only style ORs ones in; read/write style takes the written value
  function automatic logic [1:0] set_style(input logic [1:0] old, input logic [1:0] wv);
    return style_q ? (old | wv) : wv;
  endfunction

  // Handshakes; one write and one read in flight at most
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wr_go = aw_got_q && w_got_q && !bvalid_q;
  // Registers are one byte wide, so only lane 0 carries data
  assign wr_en = wr_go && wlane_q;
  assign rix = s_axi_araddr[ADDR_W-1:2];

  // Write address and data are taken in either order, then applied once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      wix_q <= '0;
      wbyte_q <= BYTE_RST;
      wlane_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        wix_q <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= reg_hit(wix_q) ? RESP_OKAY : RESP_DECERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read byte assembly; reserved and foreign bits read zero
  always_comb
  begin
    rd_byte = BYTE_RST;
    if (rix == STYLE_IX)
      rd_byte[STYLE_BIT] = style_q;
    for (int c = 0; c < NCH; c++)
    begin
      if (rix == CTRL_IX[c])
        rd_byte = ctrl_q[c];
      if (rix == IRS_IX[c])
        rd_byte = irs_q[c];
      if (rix == LVL_IX[c])
        rd_byte[LVL_POS[c] +: 3] = lvl_q[c];
      if (rix == EN_IX[c])
        rd_byte[EVT_POS[c] +: 3] = en_q[c];
      if (rix == FLG_IX[c])
        rd_byte[EVT_POS[c] +: 3] = flag_q[c];
      if (rix == DRQ_IX[c])
        rd_byte[DMA_POS[c] +: 2] = dsel_q[c];
      if (rix == DAL_IX[c])
        rd_byte[DMA_POS[c] +: 2] = dal_q[c];
    end
  end

  // Read data path; unmapped reads return zero with a decode error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= reg_hit(rix) ? RESP_OKAY : RESP_DECERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Write style for flags and DMA bits; clear-only for flags and set-only for DMA bits is the default
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      style_q <= STYLE_RST;
    else if (wr_at(STYLE_IX))
      style_q <= wbyte_q[STYLE_BIT];
  end

  // Plain configuration bytes, levels and enables
  always_ff @(posedge aclk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (!aresetn)
      begin
        ctrl_q[c] <= BYTE_RST;
        irs_q[c] <= BYTE_RST;
        lvl_q[c] <= '0;
        en_q[c] <= '0;
      end
      else
      begin
        if (wr_at(CTRL_IX[c]))
          ctrl_q[c] <= wbyte_q;
        if (wr_at(IRS_IX[c]))
          irs_q[c] <= wbyte_q;
        if (wr_at(LVL_IX[c]))
          lvl_q[c] <= wbyte_q[LVL_POS[c] +: 3];
        if (wr_at(EN_IX[c]))
          en_q[c] <= wbyte_q[EVT_POS[c] +: 3];
      end
    end
  end

  // Event flags; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (!aresetn)
        flag_q[c] <= '0;
      else if (wr_at(FLG_IX[c]))
        flag_q[c] <= (style_q ? (flag_q[c] & ~wbyte_q[EVT_POS[c] +: 3])
                              : wbyte_q[EVT_POS[c] +: 3])
                     | {line_evt[c].tx_empty, line_evt[c].rx_full | line_evt[c].rx_error,
                        line_evt[c].rx_error};
      else
        flag_q[c] <= flag_q[c] | {line_evt[c].tx_empty,
                                  line_evt[c].rx_full | line_evt[c].rx_error,
                                  line_evt[c].rx_error};
    end
  end

  // DMA request selects and allows
  always_ff @(posedge aclk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (!aresetn)
      begin
        dsel_q[c] <= '0;
        dal_q[c] <= '0;
      end
      else
      begin
        if (wr_at(DRQ_IX[c]))
          dsel_q[c] <= set_style(dsel_q[c], wbyte_q[DMA_POS[c] +: 2]);
        if (wr_at(DAL_IX[c]))
          dal_q[c] <= set_style(dal_q[c], wbyte_q[DMA_POS[c] +: 2]);
      end
    end
  end

  // Outstanding DMA transfers and their interrupt release after completion
  always_ff @(posedge aclk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (!aresetn)
      begin
        pend_q[c] <= '0;
        rel_q[c] <= '0;
      end
      else
      begin
        pend_q[c] <= (pend_q[c] & ~dma_done[c])
                     | ({line_evt[c].tx_empty, line_evt[c].rx_full} & routed[c]);
        // Release lapses with the flag so the next event waits for DMA again
        rel_q[c] <= (rel_q[c] & {flag_q[c][2], flag_q[c][1]})
                    | (dma_done[c] & dma_irq_allow[c]);
      end
    end
  end

  // Routing, gated DMA requests, eligible sources and channel config
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      routed[c] = dsel_q[c] & dal_q[c];
      dma_req[c] = pend_q[c] & routed[c];
      act[c] = flag_q[c] & en_q[c]
               & {~(routed[c][1] & ~rel_q[c][1]), ~(routed[c][0] & ~rel_q[c][0]), 1'b1};
      chan_cfg[c].transmit_allow = ctrl_q[c][TX_ALLOW_BIT];
      chan_cfg[c].receive_allow = ctrl_q[c][RX_ALLOW_BIT];
      chan_cfg[c].line_cfg = ctrl_q[c][5:0];
      chan_cfg[c].infrared_on = (irs_q[c][1:0] == IR_ON);
      chan_cfg[c].infrared_cfg = irs_q[c][7:2];
    end
  end

  // Pick the highest level among requesting channels; ties go to the lower channel
  always_comb
  begin
    best_ok = 1'b0;
    best_lvl = '0;
    best_ch = '0;
    best_src = SRC_ERR;
    for (int c = 0; c < NCH; c++)
    begin
      if ((act[c] != 3'b000) && (!best_ok || (lvl_q[c] > best_lvl)))
      begin
        best_ok = 1'b1;
        best_lvl = lvl_q[c];
        best_ch = c[1:0];
        best_src = act[c][0] ? SRC_ERR : (act[c][1] ? SRC_FULL : SRC_EMPTY);
      end
    end
  end

  // Registered channel requests, held while the flag stays set
  always_ff @(posedge aclk)
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (!aresetn)
        chan_irq_q[c] <= '{req: 1'b0, level: 3'b000, source: SRC_ERR};
      else
      begin
        chan_irq_q[c].req <= (act[c] != 3'b000);
        chan_irq_q[c].level <= lvl_q[c];
        chan_irq_q[c].source <= act[c][0] ? SRC_ERR : (act[c][1] ? SRC_FULL : SRC_EMPTY);
      end
    end
  end

  // CPU interrupt gate
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_irq_q <= 1'b0;
      cpu_lvl_q <= '0;
      cpu_ch_q <= '0;
      cpu_src_q <= SRC_ERR;
    end
    else
    begin
      cpu_irq_q <= best_ok && global_irq_allow && !higher_irq_pending
                   && (best_lvl > cpu_irq_threshold);
      cpu_lvl_q <= best_lvl;
      cpu_ch_q <= best_ch;
      cpu_src_q <= best_src;
    end
  end

  assign chan_irq = chan_irq_q;
  assign cpu_irq_req = cpu_irq_q;
  assign cpu_irq_level = cpu_lvl_q;
  assign cpu_irq_channel = cpu_ch_q;
  assign cpu_irq_source = cpu_src_q;

  // Checks on channel 0 and the gates shared by all channels
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_FULL_SETS: assert property (line_evt[0].rx_full |=> flag_q[0][1])
    else $error("receive-full event did not set its flag");
  AST_EMPTY_SETS: assert property (line_evt[0].tx_empty |=> flag_q[0][2])
    else $error("transmit-empty event did not set its flag");
  AST_ERR_BOTH: assert property (line_evt[0].rx_error |=> flag_q[0][0] && flag_q[0][1])
    else $error("receive error did not set error and full flags");
  AST_CLR_ONLY: assert property (wr_at(FLG_IX[0]) && style_q && wbyte_q[0]
                                 && !line_evt[0].rx_error |=> !flag_q[0][0])
    else $error("clear-only write of one left the flag set");
  AST_CPU_GATE: assert property (cpu_irq_req |-> $past(global_irq_allow)
                                 && !$past(higher_irq_pending)
                                 && (cpu_irq_level > $past(cpu_irq_threshold)))
    else $error("CPU interrupt raised without its conditions");
  AST_DMA_HOLD: assert property (routed[0][0] && !rel_q[0][0] |-> !act[0][1])
    else $error("DMA-routed receive event reached the CPU early");
  AST_DMA_START: assert property (line_evt[0].rx_full && routed[0][0]
                                  && !dma_done[0].rx |=> dma_req[0].rx)
    else $error("routed event did not request DMA");
  AST_DMA_ALLOW: assert property (dma_req[0].rx |-> dal_q[0][0] && dsel_q[0][0])
    else $error("DMA request passed without allow");
  AST_SET_ONLY: assert property (wr_at(DRQ_IX[0]) && style_q && dsel_q[0][0]
                                 |=> dsel_q[0][0])
    else $error("set-only write cleared a DMA select");
  AST_RST_VALS: assert property (!$past(aresetn) |-> en_q[0] == 3'b000
                                 && dsel_q[0] == 2'b00 && style_q)
    else $error("enables, selects or style wrong after reset");
  AST_HELD_REQ: assert property (flag_q[0][0] && en_q[0][0] |=> chan_irq[0].req
                                 && chan_irq[0].source == SRC_ERR)
    else $error("pending error event not presented");
  AST_BRESP: assert property (wr_go |=> s_axi_bvalid)
    else $error("write not answered");

  COV_CPU_IRQ: cover property (cpu_irq_req && cpu_irq_source == SRC_FULL);
  COV_DMA_DONE: cover property (dma_req[0].rx ##[1:20] dma_done[0].rx);
  COV_RW_STYLE: cover property (!style_q && wr_at(FLG_IX[0]));
endmodule // sidc_ctrl
`default_nettype wire

// ===== hdl/sidc_pkg.sv
// Package: register indexes, field positions and carriers of the serial IRQ/DMA control block
package sidc_pkg;
  localparam int NCH = 4;
  localparam int IDX_W = 20;
  localparam int ADDR_W = IDX_W + 2;
  // Register indexes per channel; byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IX [NCH] = '{20'h401E3, 20'h401E8, 20'h401F3, 20'h401F8};
  localparam logic [IDX_W-1:0] IRS_IX [NCH] = '{20'h401E4, 20'h401E9, 20'h401F4, 20'h401F9};
  localparam logic [IDX_W-1:0] LVL_IX [NCH] = '{20'h40269, 20'h4026A, 20'h4026E, 20'h4026E};
  localparam logic [IDX_W-1:0] EN_IX [NCH] = '{20'h40276, 20'h40276, 20'h40279, 20'h40279};
  localparam logic [IDX_W-1:0] FLG_IX [NCH] = '{20'h40286, 20'h40286, 20'h40289, 20'h40289};
  localparam logic [IDX_W-1:0] DRQ_IX [NCH] = '{20'h40292, 20'h40293, 20'h4029B, 20'h4029B};
  localparam logic [IDX_W-1:0] DAL_IX [NCH] = '{20'h40296, 20'h40297, 20'h4029C, 20'h4029C};
  localparam logic [IDX_W-1:0] STYLE_IX = 20'h402A0;
  // Field positions inside each byte register
  localparam int LVL_POS [NCH] = '{4, 0, 0, 4};
  localparam int EVT_POS [NCH] = '{0, 3, 0, 3};
  localparam int DMA_POS [NCH] = '{6, 0, 2, 4};
  localparam int TX_ALLOW_BIT = 7;
  localparam int RX_ALLOW_BIT = 6;
  localparam int STYLE_BIT = 0;
  // Reset values and codes
  localparam logic STYLE_RST = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] IR_ON = 2'b10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // Interrupt sources of one channel, listed from highest priority
  typedef enum logic [1:0] {
    SRC_ERR = 2'b00,
    SRC_FULL = 2'b01,
    SRC_EMPTY = 2'b10
  } sidc_src_e;

  // Event strobes from one serial channel core
  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic rx_error;
  } sidc_evt_s;

  // Receive and transmit pair for DMA
  typedef struct packed {
    logic tx;
    logic rx;
  } sidc_dma_s;

  // Configuration presented to one channel core
  typedef struct packed {
    logic transmit_allow;
    logic receive_allow;
    logic [5:0] line_cfg;
    logic infrared_on;
    logic [5:0] infrared_cfg;
  } sidc_cfg_s;

  // Channel interrupt request toward the interrupt logic
  typedef struct packed {
    logic req;
    logic [2:0] level;
    sidc_src_e source;
  } sidc_irq_s;
endpackage

// ===== dv/sidc_dma_model.sv
// Behavioural programmed-DMA engine facing the serial IRQ/DMA control block
`timescale 1ns/1ps
`default_nettype none
module sidc_dma_model
  import sidc_pkg::*;
#(
  parameter int LAT = 6
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request and completion
  input wire sidc_pkg::sidc_dma_s [sidc_pkg::NCH-1:0] dma_req,
  output sidc_pkg::sidc_dma_s [sidc_pkg::NCH-1:0] dma_done,
  output sidc_pkg::sidc_dma_s [sidc_pkg::NCH-1:0] dma_irq_allow
);
  logic [2*NCH-1:0] req_w;
  logic [2*NCH-1:0] done_q;
  logic [3:0] cnt_q [2*NCH];

  // Flattened view; the engine always lets the CPU hear about completion
  assign req_w = dma_req;
  assign dma_done = done_q;
  assign dma_irq_allow = {(2*NCH){1'b1}};

  // Slow transfer: done pulses LAT cycles after the request appears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_q <= '0;
      for (int i = 0; i < 2*NCH; i++) cnt_q[i] <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 2*NCH; i++)
      begin
        done_q[i] <= 1'b0;
        if (req_w[i] && !done_q[i])
        begin
          if (cnt_q[i] == 4'(LAT - 1))
          begin
            done_q[i] <= 1'b1;
            cnt_q[i] <= 4'h0;
          end
          else cnt_q[i] <= cnt_q[i] + 4'h1;
        end
        else cnt_q[i] <= 4'h0;
      end
    end
  end
endmodule // sidc_dma_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the serial IRQ/DMA control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sidc_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [2:0] prot, thr, cpu_level;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, cpu_chan;
  logic glb, hi, cpu_req;
  sidc_src_e cpu_src;
  sidc_evt_s [NCH-1:0] line_evt;
  sidc_cfg_s [NCH-1:0] chan_cfg;
  sidc_dma_s [NCH-1:0] dma_req, dma_done, dma_allow;
  sidc_irq_s [NCH-1:0] chan_irq;
  int bad_count, checks;

  sidc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_evt(line_evt),
    .chan_cfg(chan_cfg), .dma_req(dma_req), .dma_done(dma_done), .dma_irq_allow(dma_allow),
    .global_irq_allow(glb), .cpu_irq_threshold(thr), .higher_irq_pending(hi),
    .chan_irq(chan_irq), .cpu_irq_req(cpu_req), .cpu_irq_level(cpu_level),
    .cpu_irq_channel(cpu_chan), .cpu_irq_source(cpu_src));

  sidc_dma_model #(.LAT(6)) dma (.aclk(aclk), .aresetn(aresetn), .dma_req(dma_req),
    .dma_done(dma_done), .dma_irq_allow(dma_allow));

  // 250 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Mismatches %0d of %0d comparisons", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Write one byte; handshake sampled at the falling edge before each rising edge
  task automatic wr(input logic [19:0] ix, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] br;
    @(posedge aclk);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      br = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b)
      begin
        bready <= 1'b0;
        chk({30'h0, br}, {30'h0, er});
        break;
      end
    end
  endtask

  // Read one byte and compare data and response
  task automatic rd(input logic [19:0] ix, input logic [7:0] d, input logic [1:0] er);
    logic a, r;
    logic [31:0] rv;
    logic [1:0] rr;
    @(posedge aclk);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      a = arvalid && arready;
      r = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (r)
      begin
        rready <= 1'b0;
        chk(rv, {24'h000000, d});
        chk({30'h0, rr}, {30'h0, er});
        break;
      end
    end
  endtask

  // One-cycle event strobe from a channel core
  task automatic pulse(input int c, input logic [2:0] v);
    @(posedge aclk);
    line_evt[c] <= v;
    @(posedge aclk);
    line_evt[c] <= 3'h0;
  endtask

  // Drive the CPU-side levels and check the registered request
  task automatic lv(input logic g, input logic [2:0] t, input logic h, input logic e);
    @(posedge aclk);
    glb <= g;
    thr <= t;
    hi <= h;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, cpu_req}, {31'h0, e});
  endtask

  // Hang guard
  initial
  begin
    repeat (6000) @(posedge aclk);
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, glb, hi} = 8'h00;
    {awaddr, araddr, wdata, thr, prot} = '0;
    wstrb = 4'hF;
    line_evt = '0;
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(EN_IX[0], 8'h00, RESP_OKAY);
    rd(DRQ_IX[0], 8'h00, RESP_OKAY);
    rd(DAL_IX[0], 8'h00, RESP_OKAY);
    rd(CTRL_IX[0], 8'h00, RESP_OKAY);
    rd(20'h00010, 8'h00, RESP_DECERR);
    wr(20'h00010, 8'h55, RESP_DECERR);
    // Flags cleared before anything is enabled
    wr(FLG_IX[0], 8'h3F, RESP_OKAY);
    wr(FLG_IX[2], 8'h3F, RESP_OKAY);
    // Every infrared code on every channel, ending on normal
    for (int c = 0; c < NCH; c++)
      for (int k = 3; k >= 0; k--)
      begin
        wr(IRS_IX[c], {6'(c + 1), 2'(k)}, RESP_OKAY);
        rd(IRS_IX[c], {6'(c + 1), 2'(k)}, RESP_OKAY);
        chk({31'h0, chan_cfg[c].infrared_on}, {31'h0, k == 2});
        chk({26'h0, chan_cfg[c].infrared_cfg}, 32'(c + 1));
      end
    // Infrared before the mode, allows off while the mode changes
    wr(IRS_IX[1], 8'h02, RESP_OKAY);
    wr(CTRL_IX[1], 8'h03, RESP_OKAY);
    // Both allows only in an asynchronous mode
    wr(CTRL_IX[1], 8'hC3, RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, chan_cfg[1].transmit_allow}, 32'h1);
    chk({31'h0, chan_cfg[1].receive_allow}, 32'h1);
    chk({26'h0, chan_cfg[1].line_cfg}, 32'h3);
    chk({31'h0, chan_cfg[1].infrared_on}, 32'h1);
    wr(LVL_IX[0], 8'h70, RESP_OKAY);
    rd(LVL_IX[0], 8'h70, RESP_OKAY);
    wr(EN_IX[0], 8'h2A, RESP_OKAY);
    rd(EN_IX[0], 8'h2A, RESP_OKAY);
    wr(EN_IX[0], 8'h00, RESP_OKAY);
    // Receive error on channel 1 with nothing enabled
    pulse(1, 3'b001);
    rd(FLG_IX[1], 8'h18, RESP_OKAY);
    chk({31'h0, cpu_req}, 32'h0);
    wr(FLG_IX[1], 8'h08, RESP_OKAY);
    rd(FLG_IX[1], 8'h10, RESP_OKAY);
    wr(FLG_IX[1], 8'h00, RESP_OKAY);
    rd(FLG_IX[1], 8'h10, RESP_OKAY);
    wr(FLG_IX[1], 8'h10, RESP_OKAY);
    rd(FLG_IX[1], 8'h00, RESP_OKAY);
    // Read/write style, then back to the default
    wr(STYLE_IX, 8'h00, RESP_OKAY);
    wr(FLG_IX[1], 8'h05, RESP_OKAY);
    rd(FLG_IX[1], 8'h05, RESP_OKAY);
    wr(FLG_IX[1], 8'h00, RESP_OKAY);
    rd(FLG_IX[1], 8'h00, RESP_OKAY);
    wr(STYLE_IX, 8'h01, RESP_OKAY);
    // Receive-full interrupt on channel 2 at level 5
    wr(LVL_IX[2], 8'h05, RESP_OKAY);
    wr(EN_IX[2], 8'h02, RESP_OKAY);
    lv(1'b1, 3'h3, 1'b0, 1'b0);
    pulse(2, 3'b010);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, cpu_req}, 32'h1);
    chk({29'h0, cpu_level}, 32'h5);
    chk({30'h0, cpu_chan}, 32'h2);
    chk({30'h0, cpu_src}, {30'h0, SRC_FULL});
    chk({28'h0, chan_irq[2].req, chan_irq[2].level}, 32'hD);
    lv(1'b1, 3'h5, 1'b0, 1'b0);
    lv(1'b1, 3'h4, 1'b0, 1'b1);
    lv(1'b1, 3'h4, 1'b1, 1'b0);
    lv(1'b0, 3'h4, 1'b0, 1'b0);
    lv(1'b1, 3'h4, 1'b0, 1'b1);
    wr(FLG_IX[2], 8'h02, RESP_OKAY);
    lv(1'b1, 3'h4, 1'b0, 1'b0);
    // Receive-full routed to DMA on channel 0
    wr(EN_IX[0], 8'h03, RESP_OKAY);
    wr(LVL_IX[0], 8'h60, RESP_OKAY);
    wr(DRQ_IX[0], 8'h40, RESP_OKAY);
    wr(DAL_IX[0], 8'h40, RESP_OKAY);
    wr(DRQ_IX[0], 8'h00, RESP_OKAY);
    rd(DRQ_IX[0], 8'h40, RESP_OKAY);
    rd(DAL_IX[0], 8'h40, RESP_OKAY);
    pulse(0, 3'b010);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, dma_req[0].rx}, 32'h1);
    chk({31'h0, cpu_req}, 32'h0);
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, dma_req[0].rx}, 32'h0);
    chk({31'h0, cpu_req}, 32'h1);
    chk({30'h0, cpu_chan}, 32'h0);
    // Receive error on the same channel outranks the pending full event
    pulse(0, 3'b001);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({30'h0, cpu_src}, {30'h0, SRC_ERR});
    chk({30'h0, chan_irq[0].source}, {30'h0, SRC_ERR});
    wr(FLG_IX[0], 8'h03, RESP_OKAY);
    // Read/write style: a zero select gives a plain interrupt again
    wr(STYLE_IX, 8'h00, RESP_OKAY);
    wr(DRQ_IX[0], 8'h00, RESP_OKAY);
    rd(DRQ_IX[0], 8'h00, RESP_OKAY);
    wr(STYLE_IX, 8'h01, RESP_OKAY);
    pulse(0, 3'b010);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, dma_req[0].rx}, 32'h0);
    chk({31'h0, cpu_req}, 32'h1);
    // Allows dropped only once the channel is idle
    wr(CTRL_IX[1], 8'h03, RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, chan_cfg[1].transmit_allow}, 32'h0);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
